// ===== accel_status_consts.svh
// Register indices, field positions, reset values and timing counts
`ifndef ACCEL_STATUS_CONSTS_SVH
`define ACCEL_STATUS_CONSTS_SVH

// Register indices; byte address is four times the index
`define REG_ACC_X_LO    6'h12
`define REG_ACC_X_HI    6'h13
`define REG_ACC_Y_LO    6'h14
`define REG_ACC_Y_HI    6'h15
`define REG_ACC_Z_LO    6'h16
`define REG_ACC_Z_HI    6'h17
`define REG_TIME_B0     6'h18
`define REG_TIME_B1     6'h19
`define REG_TIME_B2     6'h1A
`define REG_EVENT       6'h1B
`define REG_INT_STAT    6'h1C

// Field positions
`define EVT_STARTUP_BIT 0
`define INT_FAULT_BIT   7
`define INT_STILL_BIT   6
`define INT_MOVE_BIT    5

// Reset values
`define ACC_RST         16'h0000
`define TIME_RST        24'h000000
`define EVENT_RST       8'h01
`define INT_RST         3'h0

// Timing in units of 100 ps: one time count and the core clock period
`define TICK_100PS      390625
`define CLK_PERIOD_100PS 80
`define TICK_CYCLES     (`TICK_100PS / `CLK_PERIOD_100PS)

`endif

// ===== accel_status_pkg.sv
// Types shared by the acceleration, time and event status registers
package accel_status_pkg;

    // One acceleration sample, all three axes
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } accel_sample_t;

    // Motion and fault event pulses
    typedef struct packed {
        logic fault;
        logic still;
        logic move;
    } motion_event_t;

endpackage

// ===== accel_time_event_status_regs.sv
// Acceleration sample, elapsed time and event status registers on Avalon-MM
// Functional notes
// - X sample at 0x12/0x13, resets zero
// - Y sample at 0x14/0x15, resets zero
// - Z sample at 0x16/0x17, resets zero
// - Time bits 7:0 at 0x18, 39.0625 us
// - Time bits 15:8 at 0x19, 10 ms
// - Time bits 23:16 at 0x1A, 2.56 s
// - Startup flag set on reset, read clears
// - Interrupt status clears on read, resets zero
// - Fault bit7, stillness bit6, movement bit5
// - Any data read clears fresh-sample flag
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
`include "accel_status_consts.svh"

module accel_time_event_status_regs
    import accel_status_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic          CORE_CLK,
    input  wire logic          RST,
    // Avalon-MM slave, byte address
    input  wire logic [7:0]    ADDRESS,
    input  wire logic          READ,
    input  wire logic          WRITE,
    input  wire logic [31:0]   WRITEDATA,
    input  wire logic [3:0]    BYTEENABLE,
    output logic      [31:0]   READDATA,
    output logic               WAITREQUEST,
    // Sensor core side
    input  wire accel_sample_t SAMPLE,
    input  wire logic          SAMPLE_VALID,
    input  wire motion_event_t EVENTS,
    input  wire logic          SOFT_RESET,
    // Status
    output logic               DATA_READY,
    output logic      [23:0]   ELAPSED_TICKS
);

    localparam int CNT_W = $clog2(TICK_CYCLES);
    // Startup flag reset value taken from the event register's reset byte
    localparam logic [7:0] EVENT_RST_V = `EVENT_RST;

    logic              ack_r;
    logic              rd_hit;
    logic [5:0]        idx;
    logic [31:0]       rdata_r;
    logic [7:0]        rd_mux;
    logic [15:0]       sample_axis [3];
    logic [15:0]       axis_r      [3];
    logic [7:0]        hi_snap_r   [3];
    logic              hi_lock_r   [3];
    logic [7:0]        hi_view     [3];
    logic [CNT_W-1:0]  tick_cnt_r;
    logic              tick_r;
    logic [23:0]       time_r;
    logic [15:0]       time_snap_r;
    logic              time_lock_r;
    logic [15:0]       time_view;
    logic              drdy_r;
    logic              por_r;
    logic [2:0]        int_r;
    logic [2:0]        int_set;
    logic              data_read;

    // Bus handshake: one wait cycle, then the answer for one cycle
    assign idx         = ADDRESS[7:2];
    assign WAITREQUEST = (READ | WRITE) & ~ack_r;
    assign rd_hit      = READ & ~ack_r;

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            ack_r <= 1'b0;
        else
            ack_r <= (READ | WRITE) & ~ack_r;
    end

    // Writes are answered but change nothing; every register is read-only
    assign READDATA = rdata_r;

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            rdata_r <= 32'h0000_0000;
        else if (rd_hit)
            rdata_r <= {24'h00_0000, rd_mux};
    end

    // Unpack the sample struct into an axis array
    assign sample_axis[0] = SAMPLE.x;
    assign sample_axis[1] = SAMPLE.y;
    assign sample_axis[2] = SAMPLE.z;

    // Per axis: sample hold plus high-byte freeze on low-byte read
    for (genvar g = 0; g < 3; g++)
    begin : g_axis
        localparam logic [5:0] LO_IDX = 6'(`REG_ACC_X_LO + 2 * g);
        localparam logic [5:0] HI_IDX = 6'(`REG_ACC_X_HI + 2 * g);

        always_ff @(posedge CORE_CLK)
        begin
            if (RST)
                axis_r[g] <= `ACC_RST;
            else if (SAMPLE_VALID)
                axis_r[g] <= sample_axis[g];
        end

        // Freeze keeps a low/high pair from straddling two samples
        always_ff @(posedge CORE_CLK)
        begin
            if (RST)
            begin
                hi_snap_r[g] <= 8'h00;
                hi_lock_r[g] <= 1'b0;
            end
            else if (rd_hit && idx == LO_IDX)
            begin
                hi_snap_r[g] <= axis_r[g][15:8];
                hi_lock_r[g] <= 1'b1;
            end
            else if (rd_hit && idx == HI_IDX)
                hi_lock_r[g] <= 1'b0;
        end

        assign hi_view[g] = hi_lock_r[g] ? hi_snap_r[g] : axis_r[g][15:8];
    end

    // Tick divider, one enable pulse per time count
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || SOFT_RESET)
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r == CNT_W'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r     <= 1'b0;
        end
    end

    // Elapsed time; wraps naturally at the 24-bit limit
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || SOFT_RESET)
            time_r <= `TIME_RST;
        else if (tick_r)
            time_r <= time_r + 24'h00_0001;
    end

    assign ELAPSED_TICKS = time_r;

    // Byte 0 read freezes bytes 1 and 2 until byte 2 is read
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            time_snap_r <= 16'h0000;
            time_lock_r <= 1'b0;
        end
        else if (rd_hit && idx == `REG_TIME_B0)
        begin
            time_snap_r <= time_r[23:8];
            time_lock_r <= 1'b1;
        end
        else if (rd_hit && idx == `REG_TIME_B2)
            time_lock_r <= 1'b0;
    end

    assign time_view = time_lock_r ? time_snap_r : time_r[23:8];

    // Any acceleration data read
    assign data_read = rd_hit && idx >= `REG_ACC_X_LO && idx <= `REG_ACC_Z_HI;

    // Fresh-sample flag; a new sample beats a clearing read
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            drdy_r <= 1'b0;
        else if (SAMPLE_VALID)
            drdy_r <= 1'b1;
        else if (data_read)
            drdy_r <= 1'b0;
    end

    assign DATA_READY = drdy_r;

    // Startup flag; soft reset beats a clearing read
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            por_r <= EVENT_RST_V[`EVT_STARTUP_BIT];
        else if (SOFT_RESET)
            por_r <= 1'b1;
        else if (rd_hit && idx == `REG_EVENT)
            por_r <= 1'b0;
    end

    // Sticky events: fault, stillness, movement
    assign int_set = {EVENTS.fault, EVENTS.still, EVENTS.move};

    // Event in the clearing cycle survives the read
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            int_r <= `INT_RST;
        else if (rd_hit && idx == `REG_INT_STAT)
            int_r <= int_set;
        else
            int_r <= int_r | int_set;
    end

    // Read mux; unmapped and reserved bits read zero
    always_comb
    begin
        rd_mux = 8'h00;
        case (idx)
            `REG_ACC_X_LO: rd_mux = axis_r[0][7:0];
            `REG_ACC_X_HI: rd_mux = hi_view[0];
            `REG_ACC_Y_LO: rd_mux = axis_r[1][7:0];
            `REG_ACC_Y_HI: rd_mux = hi_view[1];
            `REG_ACC_Z_LO: rd_mux = axis_r[2][7:0];
            `REG_ACC_Z_HI: rd_mux = hi_view[2];
            `REG_TIME_B0:  rd_mux = time_r[7:0];
            `REG_TIME_B1:  rd_mux = time_view[7:0];
            `REG_TIME_B2:  rd_mux = time_view[15:8];
            `REG_EVENT:    rd_mux[`EVT_STARTUP_BIT] = por_r;
            `REG_INT_STAT:
            begin
                rd_mux[`INT_FAULT_BIT] = int_r[2];
                rd_mux[`INT_STILL_BIT] = int_r[1];
                rd_mux[`INT_MOVE_BIT]  = int_r[0];
            end
            default:       rd_mux = 8'h00;
        endcase
    end

    // Checks

    sequence x_lo_read_s;
        rd_hit && idx == `REG_ACC_X_LO;
    endsequence

    sequence time_b0_read_s;
        rd_hit && idx == `REG_TIME_B0;
    endsequence

    bus_answer_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (READ && WAITREQUEST) |=> !WAITREQUEST && ack_r)
        else $error("read not answered after one wait cycle");

    x_reset_a: assert property (@(posedge CORE_CLK)
        RST |=> axis_r[0] == 16'h0000 && rdata_r == 32'h0000_0000)
        else $error("x sample not zero after reset");

    y_load_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        SAMPLE_VALID |=> axis_r[1] == $past(SAMPLE.y))
        else $error("y sample not captured");

    z_hi_read_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (rd_hit && idx == `REG_ACC_Z_HI && !hi_lock_r[2])
        |=> READDATA == {24'h00_0000, $past(axis_r[2][15:8])})
        else $error("z high byte read wrong");

    tick_step_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (tick_r && !SOFT_RESET) |=> !tick_r && tick_cnt_r == CNT_W'(1))
        else $error("tick divider not restarted");

    time_b1_read_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (rd_hit && idx == `REG_TIME_B1 && time_lock_r)
        |=> READDATA[7:0] == $past(time_snap_r[7:0]))
        else $error("time byte 1 not frozen");

    time_wrap_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (tick_r && time_r == 24'hFF_FFFF && !SOFT_RESET) |=> time_r == 24'h00_0000)
        else $error("time did not wrap");

    time_count_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (tick_r && !SOFT_RESET) |=> time_r == $past(time_r) + 24'h00_0001)
        else $error("time did not advance on tick");

    por_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (rd_hit && idx == `REG_EVENT && por_r && !SOFT_RESET)
        |=> !por_r && READDATA == 32'h0000_0001)
        else $error("startup flag read or clear wrong");

    int_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (rd_hit && idx == `REG_INT_STAT && int_set == 3'h0) |=> int_r == 3'h0)
        else $error("status not cleared on read");

    fault_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        EVENTS.fault |=> int_r[2] ##1 (int_r[2] || $past(rd_hit)))
        else $error("fault event lost");

    drdy_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (data_read && !SAMPLE_VALID) |=> !DATA_READY)
        else $error("fresh flag not cleared by data read");

    x_freeze_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        x_lo_read_s |=> hi_lock_r[0] && hi_snap_r[0] == $past(axis_r[0][15:8]))
        else $error("x high byte not frozen");

    time_freeze_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        time_b0_read_s |=> time_lock_r && time_snap_r == $past(time_r[23:8]))
        else $error("time upper bytes not frozen");

    move_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        EVENTS.move |=> int_r[0])
        else $error("movement event lost");

    still_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        EVENTS.still |=> int_r[1])
        else $error("stillness event lost");

    int_layout_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (rd_hit && idx == `REG_INT_STAT) |=> READDATA == {24'h00_0000, $past(int_r), 5'h00})
        else $error("status bit layout wrong");

    drdy_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        SAMPLE_VALID |=> DATA_READY)
        else $error("fresh flag lost to a data read");

    por_set_a: assert property (@(posedge CORE_CLK)
        (RST || SOFT_RESET) |=> por_r)
        else $error("startup flag not set by reset");

    soft_time_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        SOFT_RESET |=> time_r == 24'h00_0000 && tick_cnt_r == '0 && !tick_r)
        else $error("soft reset did not zero time");

    y_frozen_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (rd_hit && idx == `REG_ACC_Y_HI && hi_lock_r[1])
        |=> READDATA == {24'h00_0000, $past(hi_snap_r[1])} && !hi_lock_r[1])
        else $error("y high byte not read frozen");

    time_unlock_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (rd_hit && idx == `REG_TIME_B2) |=> !time_lock_r)
        else $error("time bytes stay frozen");

    write_answer_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (WRITE && WAITREQUEST) |=> !WAITREQUEST && rdata_r == $past(rdata_r))
        else $error("write not answered or changed read data");

endmodule

// ===== avalon_host_model.sv
// Host model issuing Avalon-MM register accesses
`timescale 1ns/100ps
module avalon_host_model
(
    // Clock
    input  wire logic        clk,
    // Avalon-MM master side
    output logic      [7:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    // Idle bus from time zero
    initial
    begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
    end

    // Request held until waitrequest is seen low; data taken at that edge
    task automatic access(input logic wr, input logic [5:0] idx, output logic [31:0] data);
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= 32'hFFFFFFFF;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        data = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

// ===== accel_time_event_status_regs_tb.sv
// Self-checking bench for the acceleration, time and event status registers
`timescale 1ns/100ps
`include "accel_status_consts.svh"
module accel_time_event_status_regs_tb;
    import accel_status_pkg::*;
    // Short tick keeps the time counter tests brief
    localparam int TICKS = 8;
    logic          core_clk = 1'b0;
    logic          rst = 1'b1;
    logic [7:0]    addr;
    logic          rd_en;
    logic          wr_en;
    logic [31:0]   wdata;
    logic [3:0]    ben;
    logic [31:0]   rdata;
    logic          wait_req;
    accel_sample_t sample = '0;
    logic          sample_vld = 1'b0;
    motion_event_t events = '0;
    logic          soft_rst = 1'b0;
    logic          data_rdy;
    logic [23:0]   ticks;
    logic [23:0]   hold;
    logic [31:0]   d;
    int            miscompares = 0;
    int            comparisons = 0;

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    accel_time_event_status_regs #(.TICK_CYCLES(TICKS)) u_accel_time_event_status_regs (
        .CORE_CLK(core_clk), .RST(rst), .ADDRESS(addr), .READ(rd_en), .WRITE(wr_en),
        .WRITEDATA(wdata), .BYTEENABLE(ben), .READDATA(rdata), .WAITREQUEST(wait_req),
        .SAMPLE(sample), .SAMPLE_VALID(sample_vld), .EVENTS(events),
        .SOFT_RESET(soft_rst), .DATA_READY(data_rdy), .ELAPSED_TICKS(ticks));

    avalon_host_model u_avalon_host_model (
        .clk(core_clk), .address(addr), .read(rd_en), .write(wr_en), .writedata(wdata),
        .byteenable(ben), .readdata(rdata), .waitrequest(wait_req));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] q);
        u_avalon_host_model.access(1'b0, idx, q);
    endtask

    // One-cycle sample strobe; y and z offset from x
    task automatic push_sample(input logic [15:0] v);
        @(posedge core_clk);
        sample <= '{x: v, y: v + 16'h1111, z: v + 16'h2222};
        sample_vld <= 1'b1;
        @(posedge core_clk);
        sample_vld <= 1'b0;
        #1;
    endtask

    task automatic pulse_events(input motion_event_t e);
        @(posedge core_clk);
        events <= e;
        @(posedge core_clk);
        events <= '0;
    endtask

    task automatic test_reset();
        chk("ticks", 32'h0, ticks);
        chk("ready", 32'h0, data_rdy);
        for (int r = 'h12; r < 'h18; r++)
        begin
            rd(6'(r), d);
            chk("axis byte", 32'h0, d);
        end
        rd(`REG_TIME_B1, d);
        chk("time b1", 32'h0, d);
        rd(`REG_TIME_B2, d);
        chk("time b2", 32'h0, d);
        rd(`REG_INT_STAT, d);
        chk("status", 32'h0, d);
        rd(`REG_EVENT, d);
        chk("startup", 32'h1, d);
        rd(`REG_EVENT, d);
        chk("startup clr", 32'h0, d);
        rd(6'h30, d);
        chk("unmapped", 32'h0, d);
    endtask

    // Low read clears ready and freezes high; second high read is live
    task automatic test_accel();
        logic [5:0] lo;
        for (int i = 0; i < 3; i++)
        begin
            lo = `REG_ACC_X_LO + 6'(2 * i);
            push_sample(16'hA1B2);
            chk("ready set", 32'h1, data_rdy);
            rd(lo, d);
            chk("low", {24'h0, 8'hB2 + 8'(i) * 8'h11}, d);
            chk("ready clr", 32'h0, data_rdy);
            push_sample(16'h3C4D);
            rd(lo + 6'h1, d);
            chk("frozen high", {24'h0, 8'hA1 + 8'(i) * 8'h11}, d);
            chk("ready clr hi", 32'h0, data_rdy);
            rd(lo + 6'h1, d);
            chk("live high", {24'h0, 8'h3C + 8'(i) * 8'h11}, d);
        end
    endtask

    task automatic test_status();
        for (int b = 5; b < 8; b++)
        begin
            pulse_events(motion_event_t'(3'h1 << (b - 5)));
            rd(`REG_INT_STAT, d);
            chk("status bit", 32'h1 << b, d);
            rd(`REG_INT_STAT, d);
            chk("status clr", 32'h0, d);
        end
        pulse_events(3'h7);
        u_avalon_host_model.access(1'b1, `REG_INT_STAT, d);
        rd(`REG_INT_STAT, d);
        chk("status all", 32'hE0, d);
    endtask

    task automatic test_time();
        @(posedge core_clk);
        #1;
        hold = ticks;
        repeat (80) @(posedge core_clk);
        #1;
        chk("tick rate", {8'h0, hold + 24'hA}, ticks);
        while (ticks[7:0] !== 8'hF8)
            @(posedge core_clk);
        hold = ticks;
        rd(`REG_TIME_B0, d);
        chk("byte0 live", 32'h1, d[7:0] - hold[7:0] < 8'h3);
        repeat (200) @(posedge core_clk);
        rd(`REG_TIME_B1, d);
        chk("frozen b1", {24'h0, hold[15:8]}, d);
        rd(`REG_TIME_B2, d);
        chk("frozen b2", {24'h0, hold[23:16]}, d);
        rd(`REG_TIME_B1, d);
        chk("live b1", {24'h0, hold[15:8] + 8'h1}, d);
    endtask

    task automatic test_soft();
        @(posedge core_clk);
        soft_rst <= 1'b1;
        @(posedge core_clk);
        soft_rst <= 1'b0;
        #1;
        chk("time zeroed", 32'h0, ticks);
        rd(`REG_EVENT, d);
        chk("startup again", 32'h1, d);
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        test_reset();
        test_accel();
        test_status();
        test_time();
        test_soft();
        conclude();
    end

    // Watchdog, well past the expected few thousand cycles
    initial
    begin
        #(20000 * 8);
        miscompares++;
        conclude();
    end
endmodule
